// File: ivc_arbiter.sv
// Priority arbiter: highest level wins, lowest index breaks ties
`timescale 1ns/1ps
module ivc_arbiter
   import ivc_pkg::*;
(
   // Requests
   input  wire logic [NUM_VEC-1:0]            req_i,
   input  wire logic [NUM_VEC-1:0][LVL_W-1:0] lvl_i,
   // Winner
   output logic                               valid_o,
   output logic [VEC_W-1:0]                   index_o,
   output logic [LVL_W-1:0]                   level_o
);

   // Scanning downward with >= leaves the lowest index on a tie
   always_comb begin
      valid_o = 1'b0;
      index_o = '0;
      level_o = '0;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (req_i[i] && (!valid_o || lvl_i[i] >= level_o)) begin
            valid_o = 1'b1;
            index_o = VEC_W'(i);
            level_o = lvl_i[i];
         end
      end
   end

endmodule // ivc_arbiter

// File: ivc_controller.sv
// Interrupt vector controller top level
//
// What this block does
// - All peripheral, external and trap requests merge into one CPU request.
// - Software sets each user source to a level; higher level wins.
// - Equal levels resolve to the lowest vector number.
// - Primary table starts at 000004h: 8 traps then 118 sources.
// - Each entry gives a 24-bit service routine start address.
// - Alternate-table select set makes every vector use the alternate table.
// - Alternate table mirrors primary at a fixed offset; trap 0 at 000104h.
// - Reset clears all state; entry address starts at 000000h.
// - Traps: oscillator 1, address 2, stack 3, math 4; rest reserved.
// - Source n sits at 000014h plus 2n, alternate 000114h plus 2n.
// - Every source owns a distinct vector number and table entry.
// - Entry and return each take a fixed number of cycles.
// - Flags set by hardware, cleared only by software; enables gate source requests, not flags.
// - Each user source has a 3-bit priority field.
// - CPU level 7 or above blocks user sources; only traps pass.
// - Acceptance latches vector number and new level into status.
`timescale 1ns/1ps
module ivc_controller
   import ivc_pkg::*;
(
   // Clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             reset_i,
   // Source side
   input  wire logic [NUM_SRC-1:0]               source_event_i,
   input  wire logic [NUM_SRC-1:0]               source_flag_clear_i,
   input  wire logic [NUM_SRC-1:0]               source_enable_regs_i,
   input  wire logic [NUM_SRC-1:0][PRIO_W-1:0]   source_priority_regs_i,
   input  wire logic [NUM_TRAP-1:0]              trap_event_i,
   input  wire logic [NUM_TRAP-1:0]              trap_flag_clear_i,
   // Configuration
   input  wire logic                             alt_table_select_i,
   input  wire logic [LVL_W-1:0]                 cpu_priority_level_i,
   // CPU handshake
   input  wire logic                             cpu_accept_i,
   input  wire logic                             cpu_return_i,
   // Status and request
   output logic [NUM_SRC-1:0]                    source_flag_regs_o,
   output logic [NUM_TRAP-1:0]                   trap_flag_o,
   output logic                                  irq_o,
   output ivc_vector_t                           irq_vector_o,
   output ivc_taken_t                            taken_vector_status_o,
   output logic                                  entry_valid_o,
   output logic [ADDR_W-1:0]                     entry_addr_o,
   output logic                                  return_done_o,
   output logic                                  busy_o
);

   // ------------------------------------------------------------------
   // Flags
   // ------------------------------------------------------------------
   logic [NUM_SRC-1:0]  src_flag_reg, src_flag_next;
   logic [NUM_TRAP-1:0] trap_flag_reg, trap_flag_next;

   // An event in the clearing cycle survives: set beats clear
   always_comb begin
      src_flag_next  = (src_flag_reg & ~source_flag_clear_i)
                       | source_event_i;
      trap_flag_next = ((trap_flag_reg & ~trap_flag_clear_i)
                       | trap_event_i) & TRAP_IMPL_MASK;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         src_flag_reg  <= '0;
         trap_flag_reg <= '0;
      end else begin
         src_flag_reg  <= src_flag_next;
         trap_flag_reg <= trap_flag_next;
      end
   end

   // ------------------------------------------------------------------
   // Request vector in unified numbering
   // ------------------------------------------------------------------
   logic [NUM_VEC-1:0]            vec_req;
   logic [NUM_VEC-1:0][LVL_W-1:0] vec_lvl;

   // Traps rank 15 down to 8 by number, so the lowest number leads
   genvar gt;
   generate
      for (gt = 0; gt < NUM_TRAP; gt++) begin : g_trap
         assign vec_lvl[gt] = TRAP_TOP_LVL - LVL_W'(gt);
         assign vec_req[gt] = trap_flag_reg[gt]
                              && (vec_lvl[gt] > cpu_priority_level_i);
      end
      for (gt = 0; gt < NUM_SRC; gt++) begin : g_src
         // User levels never exceed 7, so CPU level 7 masks them all
         assign vec_lvl[NUM_TRAP+gt] =
            {1'b0, source_priority_regs_i[gt]};
         assign vec_req[NUM_TRAP+gt] = src_flag_reg[gt]
            && source_enable_regs_i[gt]
            && (vec_lvl[NUM_TRAP+gt] > cpu_priority_level_i);
      end
   endgenerate

   logic             win_valid;
   logic [VEC_W-1:0] win_index;
   logic [LVL_W-1:0] win_level;

   ivc_arbiter u_arbiter (
      .req_i   (vec_req),
      .lvl_i   (vec_lvl),
      .valid_o (win_valid),
      .index_o (win_index),
      .level_o (win_level)
   );

   // ------------------------------------------------------------------
   // Service sequencer
   // ------------------------------------------------------------------
   ivc_state_t        state_reg, state_next;
   logic [2:0]        cnt_reg, cnt_next;
   logic              irq_reg, irq_next;
   ivc_vector_t       vec_reg, vec_next;
   ivc_taken_t        taken_reg, taken_next;
   logic              entry_valid_reg, entry_valid_next;
   logic [ADDR_W-1:0] entry_addr_reg, entry_addr_next;
   logic              ret_done_reg, ret_done_next;
   logic              accepted;

   assign accepted = (state_reg == S_IDLE) && irq_reg && cpu_accept_i;

   always_comb begin
      state_next       = state_reg;
      cnt_next         = cnt_reg;
      taken_next       = taken_reg;
      entry_addr_next  = entry_addr_reg;
      entry_valid_next = 1'b0;
      ret_done_next    = 1'b0;
      unique case (state_reg)
         S_IDLE: begin
            if (accepted) begin
               taken_next.taken_vector_number  = vec_reg.number;
               taken_next.taken_priority_level = vec_reg.level;
               state_next = S_ENTRY;
               cnt_next   = CNT_ZERO;
            end else if (cpu_return_i) begin
               state_next = S_RETURN;
               cnt_next   = CNT_ZERO;
            end
         end
         S_ENTRY: begin
            // Count never depends on the vector, so latency is constant
            if (cnt_reg == ENTRY_CYCLES - 3'h1) begin
               entry_valid_next = 1'b1;
               entry_addr_next  = vec_reg.addr;
               state_next       = S_IDLE;
            end else begin
               cnt_next = cnt_reg + 3'h1;
            end
         end
         S_RETURN: begin
            if (cnt_reg == RETURN_CYCLES - 3'h1) begin
               ret_done_next = 1'b1;
               state_next    = S_IDLE;
            end else begin
               cnt_next = cnt_reg + 3'h1;
            end
         end
      endcase
      // Request is held off while a sequence runs
      irq_next           = win_valid && (state_next == S_IDLE);
      vec_next.number    = win_index;
      vec_next.level     = win_level;
      vec_next.addr      = ivc_vec_addr(win_index,
                                        alt_table_select_i);
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg       <= S_IDLE;
         cnt_reg         <= CNT_ZERO;
         irq_reg         <= 1'b0;
         vec_reg         <= '0;
         taken_reg       <= '0;
         entry_valid_reg <= 1'b0;
         entry_addr_reg  <= RESET_ADDR;
         ret_done_reg    <= 1'b0;
      end else begin
         state_reg       <= state_next;
         cnt_reg         <= cnt_next;
         irq_reg         <= irq_next;
         vec_reg         <= vec_next;
         taken_reg       <= taken_next;
         entry_valid_reg <= entry_valid_next;
         entry_addr_reg  <= entry_addr_next;
         ret_done_reg    <= ret_done_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   logic busy_reg;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (state_next != S_IDLE);
      end
   end

   assign source_flag_regs_o    = src_flag_reg;
   assign trap_flag_o           = trap_flag_reg;
   assign irq_o                 = irq_reg;
   assign irq_vector_o          = vec_reg;
   assign taken_vector_status_o = taken_reg;
   assign entry_valid_o         = entry_valid_reg;
   assign entry_addr_o          = entry_addr_reg;
   assign return_done_o         = ret_done_reg;
   assign busy_o                = busy_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   flag_set_a: assert property (
      ##1 ((src_flag_reg & $past(source_event_i)) == $past(source_event_i)))
      else $error("source event did not set its flag");

   flag_hold_a: assert property (
      ##1 (($past(src_flag_reg) & ~src_flag_reg
            & ~$past(source_flag_clear_i)) == '0))
      else $error("source flag dropped without a software clear");

   trap_rsvd_a: assert property (
      (trap_flag_reg & ~TRAP_IMPL_MASK) == '0)
      else $error("reserved trap flag became set");

   irq_level_a: assert property (
      ##1 irq_o |-> irq_vector_o.level > $past(cpu_priority_level_i))
      else $error("request raised at or below CPU level");

   user_block_a: assert property (
      ##1 (irq_o && $past(cpu_priority_level_i) >= 4'h7)
      |-> irq_vector_o.level[3] && irq_vector_o.number < 7'h08)
      else $error("user source passed a blocking CPU level");

   table_addr_a: assert property (
      ##1 irq_o |-> irq_vector_o.addr[23:9] == '0
         && irq_vector_o.addr[8] == $past(alt_table_select_i)
         && irq_vector_o.addr[7:0] == {irq_vector_o.number, 1'b0} + 8'h04)
      else $error("vector address does not match table layout");

   entry_lat_a: assert property (
      accepted |=> !entry_valid_o [*4] ##1 entry_valid_o)
      else $error("entry latency is not four cycles");

   entry_addr_a: assert property (
      accepted |-> ##5 entry_addr_o == $past(vec_reg.addr, 5))
      else $error("entry address differs from accepted vector");

   return_lat_a: assert property (
      (state_reg == S_IDLE && !accepted && cpu_return_i)
      |-> ##4 return_done_o)
      else $error("return latency is not three cycles");

   taken_latch_a: assert property (
      accepted |=> taken_vector_status_o.taken_vector_number
                   == $past(vec_reg.number)
         && taken_vector_status_o.taken_priority_level
                   == $past(vec_reg.level))
      else $error("taken status not latched on acceptance");

   // Busy and request are exclusive, so an accept never races a sequence
   busy_no_irq_a: assert property (
      busy_o |-> !irq_o)
      else $error("request shown while a sequence runs");

   entry_busy_a: assert property (
      accepted |=> busy_o [*4] ##1 !busy_o)
      else $error("busy does not span the entry sequence");

   no_source_a: assert property (
      ##1 ($past(trap_flag_reg) == '0
           && $past(src_flag_reg & source_enable_regs_i) == '0)
      |-> !irq_o)
      else $error("request raised with nothing pending");

   trap_first_a: assert property (
      ##1 (irq_o && $past(trap_flag_reg[TRAP_OSC_FAIL])
           && $past(cpu_priority_level_i) < 4'hE)
      |-> irq_vector_o.number == {4'h0, TRAP_OSC_FAIL})
      else $error("oscillator trap did not win arbitration");

   user_tie_a: assert property (
      ##1 (irq_o && $past(src_flag_reg[0] && source_enable_regs_i[0])
           && irq_vector_o.level
              == {1'b0, $past(source_priority_regs_i[0])})
      |-> irq_vector_o.number == USER_BASE)
      else $error("source 0 lost a tie at its own level");

   trap_taken_c: cover property (accepted && vec_reg.number < 7'h08);
   user_taken_c: cover property (accepted && vec_reg.number >= 7'h08);
   alt_entry_c:  cover property (entry_valid_o && entry_addr_o[8]);
   return_c:     cover property (return_done_o);

endmodule // ivc_controller

// File: ivc_cpu_model.sv
// CPU core stand-in that takes one request, then runs entry and return
`timescale 1ns/1ps
module ivc_cpu_model (
   // Clock and control from the bench
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [1:0] slow_i,
   // Controller outputs
   input  wire logic       irq_i,
   input  wire logic       busy_i,
   input  wire logic       entry_valid_i,
   input  wire logic       return_done_i,
   // Handshake and measured latencies
   output logic            accept_o,
   output logic            return_o,
   output logic            done_o,
   output int              entry_lat_o,
   output int              ret_lat_o
);
   initial begin
      accept_o = 1'b0;
      return_o = 1'b0;
      done_o = 1'b0;
   end
   always begin
      @(posedge go_i);
      done_o = 1'b0;
      @(negedge clk_i);
      // Slow mode lets the request wait before the core reacts
      repeat (slow_i) @(negedge clk_i);
      // Accept only a request offered while the controller is idle
      while (!(irq_i && !busy_i)) @(negedge clk_i);
      accept_o = 1'b1;
      @(negedge clk_i);
      accept_o = 1'b0;
      entry_lat_o = 0;
      while (!entry_valid_i && entry_lat_o < 50) begin
         @(negedge clk_i);
         entry_lat_o++;
      end
      repeat (slow_i) @(negedge clk_i);
      return_o = 1'b1;
      @(negedge clk_i);
      return_o = 1'b0;
      ret_lat_o = 0;
      while (!return_done_i && ret_lat_o < 50) begin
         @(negedge clk_i);
         ret_lat_o++;
      end
      done_o = 1'b1;
   end
endmodule // ivc_cpu_model

// File: ivc_pkg.sv
// Shared constants and carrier types for the interrupt vector controller
package ivc_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int NUM_SRC  = 118;
   localparam int NUM_TRAP = 8;
   localparam int NUM_VEC  = NUM_TRAP + NUM_SRC;
   localparam int VEC_W    = 7;
   localparam int LVL_W    = 4;
   localparam int PRIO_W   = 3;
   localparam int ADDR_W   = 24;

   // ------------------------------------------------------------------
   // Table layout and reset entry
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] PRIMARY_BASE = 24'h00_0004;
   localparam logic [ADDR_W-1:0] ALT_OFFSET   = 24'h00_0100;
   localparam logic [ADDR_W-1:0] RESET_ADDR   = 24'h00_0000;
   localparam logic [VEC_W-1:0]  USER_BASE    = 7'h08;

   // ------------------------------------------------------------------
   // Trap numbers; 0, 5, 6 and 7 are reserved
   // ------------------------------------------------------------------
   localparam logic [2:0] TRAP_OSC_FAIL  = 3'h1;
   localparam logic [2:0] TRAP_ADDR_ERR  = 3'h2;
   localparam logic [2:0] TRAP_STACK_ERR = 3'h3;
   localparam logic [2:0] TRAP_MATH_ERR  = 3'h4;
   localparam logic [NUM_TRAP-1:0] TRAP_IMPL_MASK = 8'h1E;
   localparam logic [LVL_W-1:0] TRAP_TOP_LVL = 4'hF;

   // ------------------------------------------------------------------
   // Fixed latencies, in clock cycles
   // ------------------------------------------------------------------
   localparam logic [2:0] ENTRY_CYCLES  = 3'h4;
   localparam logic [2:0] RETURN_CYCLES = 3'h3;
   localparam logic [2:0] CNT_ZERO      = 3'h0;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [VEC_W-1:0]  number;
      logic [LVL_W-1:0]  level;
      logic [ADDR_W-1:0] addr;
   } ivc_vector_t;

   typedef struct packed {
      logic [VEC_W-1:0] taken_vector_number;
      logic [LVL_W-1:0] taken_priority_level;
   } ivc_taken_t;

   typedef enum logic [1:0] {S_IDLE, S_ENTRY, S_RETURN} ivc_state_t;

   // Table entry address for a unified vector number
   function automatic logic [ADDR_W-1:0] ivc_vec_addr(
      input logic [VEC_W-1:0] num,
      input logic             alt);
      logic [ADDR_W-1:0] base;
      base = alt ? (PRIMARY_BASE + ALT_OFFSET) : PRIMARY_BASE;
      return base + {{(ADDR_W-VEC_W-1){1'b0}}, num, 1'b0};
   endfunction

endpackage

// File: tb_top.sv
// Self-checking bench for the interrupt vector controller
`timescale 1ns/1ps
module tb_top;
   import ivc_pkg::*;
   logic                           clk_i = 1'b0;
   logic                           reset_i, alt, go, acc, ret, done;
   logic [NUM_SRC-1:0]             ev_s, clr_s, en_s, sf, flags_o;
   logic [NUM_SRC-1:0][PRIO_W-1:0] pr_s;
   logic [NUM_TRAP-1:0]            ev_t, clr_t, tf, tflags_o;
   logic [LVL_W-1:0]               cpu;
   logic [1:0]                     slow;
   logic                           irq, ev_o, rd_o, busy, exp_irq;
   ivc_vector_t                    vec_o;
   ivc_taken_t                     taken_o;
   logic [ADDR_W-1:0]              eaddr;
   logic [34:0]                    exp_vec;
   int                             fail_count, checked, elat, rlat;
   int                             cycles = 0;

   ivc_controller u_ivc_controller (
      .clk_i(clk_i), .reset_i(reset_i), .source_event_i(ev_s),
      .source_flag_clear_i(clr_s), .source_enable_regs_i(en_s),
      .source_priority_regs_i(pr_s), .trap_event_i(ev_t),
      .trap_flag_clear_i(clr_t), .alt_table_select_i(alt),
      .cpu_priority_level_i(cpu), .cpu_accept_i(acc), .cpu_return_i(ret),
      .source_flag_regs_o(flags_o), .trap_flag_o(tflags_o), .irq_o(irq),
      .irq_vector_o(vec_o), .taken_vector_status_o(taken_o),
      .entry_valid_o(ev_o), .entry_addr_o(eaddr), .return_done_o(rd_o),
      .busy_o(busy));

   ivc_cpu_model u_ivc_cpu_model (
      .clk_i(clk_i), .go_i(go), .slow_i(slow), .irq_i(irq), .busy_i(busy),
      .entry_valid_i(ev_o), .return_done_i(rd_o), .accept_o(acc),
      .return_o(ret), .done_o(done), .entry_lat_o(elat), .ret_lat_o(rlat));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // Hang guard: the whole run needs about 600 cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Reference arbitration: traps first, then level, then lowest number
   task automatic calc(output logic v, output logic [34:0] vec);
      int bn;
      int bl;
      bn = 0;
      bl = -1;
      for (int k = 1; k < 5; k++)
         if (tf[k] && 15 - k > cpu && 15 - k > bl) begin
            bl = 15 - k;
            bn = k;
         end
      for (int n = 0; n < NUM_SRC; n++)
         if (sf[n] && en_s[n] && pr_s[n] > cpu && int'(pr_s[n]) > bl) begin
            bl = pr_s[n];
            bn = 8 + n;
         end
      v = (bl >= 0);
      vec = {7'(bn), 4'(bl), 24'(4 + 2 * bn + (alt ? 256 : 0))};
   endtask

   task automatic pulse(input logic [NUM_SRC-1:0] es, input logic
                        [NUM_SRC-1:0] cs, input logic [7:0] et, ct);
      ev_s = es;
      clr_s = cs;
      ev_t = et;
      clr_t = ct;
      sf = (sf & ~cs) | es;
      tf = (tf & ~ct) | (et & 8'h1E);
      @(negedge clk_i);
      ev_s = '0;
      clr_s = '0;
      ev_t = '0;
      clr_t = '0;
      @(negedge clk_i);
      calc(exp_irq, exp_vec);
      chk(128'(flags_o), 128'(sf));
      chk(128'(tflags_o), 128'(tf));
      chk(128'(irq), 128'(exp_irq));
      if (exp_irq) chk(128'(vec_o), 128'(exp_vec));
   endtask

   task automatic take();
      int k;
      slow = 2'($urandom);
      go = 1'b1;
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while (!done && k < 100);
      go = 1'b0;
      chk(128'(eaddr), 128'(exp_vec[23:0]));
      chk(128'(taken_o), 128'(exp_vec[34:24]));
      chk(128'(elat), 128'd4);
      chk(128'(rlat), 128'd3);
   endtask

   function automatic logic [NUM_SRC-1:0] rnd();
      return NUM_SRC'({$urandom, $urandom, $urandom, $urandom});
   endfunction

   initial begin
      {ev_s, clr_s, en_s, sf, pr_s, ev_t, clr_t, tf} = '0;
      {alt, go, slow, cpu, fail_count, checked} = '0;
      reset_i = 1'b1;
      void'($urandom(32'h5450));
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      chk(128'(eaddr), 128'(RESET_ADDR));
      chk(128'({irq, busy, ev_o, rd_o, taken_o}), 128'd0);
      $display("test reset done");
      en_s = '1;
      pr_s = {NUM_SRC{3'h5}};
      cpu = 4'h3;
      pulse(NUM_SRC'(1) | (NUM_SRC'(1) << 13) | (NUM_SRC'(1) << 117),
            '0, 8'h00, 8'h00);
      take();
      pulse(NUM_SRC'(1) << 5, '1, 8'h00, 8'hFF);
      take();
      alt = 1'b1;
      pulse(NUM_SRC'(1) << 117, '1, 8'h00, 8'h00);
      take();
      $display("test directed done");
      reset_i = 1'b1;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      sf = '0;
      tf = '0;
      chk(128'(flags_o), 128'd0);
      chk(128'({tflags_o, eaddr}), 128'(RESET_ADDR));
      chk(128'({irq, busy, ev_o, rd_o, taken_o}), 128'd0);
      $display("test mid reset done");
      cpu = 4'h7;
      for (int k = 0; k < 8; k++) begin
         alt = k[0];
         pulse('1, '0, 8'(1 << k), ~8'(1 << k));
         if (exp_irq === 1'b1) take();
      end
      pulse('0, '1, 8'h00, 8'hFF);
      $display("test traps done");
      repeat (24) begin
         en_s = rnd();
         for (int n = 0; n < NUM_SRC; n++) pr_s[n] = 3'($urandom);
         cpu = 4'($urandom % 10);
         alt = 1'($urandom);
         pulse(rnd() & rnd() & rnd(), '0, 8'($urandom), 8'h00);
         if (exp_irq === 1'b1) take();
         pulse('0, '1, 8'h00, 8'hFF);
      end
      $display("test random done");
      summarize();
   end
endmodule // tb_top
